/* core/wetting_pkg.sv */
// Package with constants and carrier types for the relay wetting sequencer.
package wetting_pkg;
   // System clock rate and the coil pulse timing derived from it.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned PULSE_RATE_HZ = 1;
   localparam int unsigned PERIOD_CYCLES = CLK_HZ / PULSE_RATE_HZ;
   // Duty figures in percent of on time.
   localparam int unsigned DUTY_BISTABLE_PCT = 50;
   localparam int unsigned DUTY_MONOSTABLE_PCT = 45;
   localparam int unsigned PCT_FULL = 100;
   // Number of coil pulses in one burst.
   localparam int unsigned BURST_PULSES = 20;
   // Debounce settle time in microseconds and its cycle count.
   localparam int unsigned DEBOUNCE_US = 10_000;
   localparam int unsigned US_PER_S = 1_000_000;
   localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / US_PER_S) * DEBOUNCE_US;
   // Contacts monitored per kind (normally open, normally closed).
   localparam int unsigned CONTACTS = 4;
   localparam int unsigned NUM_SWITCHES = 3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ON = 2'b01,
      ST_OFF = 2'b10
   } seq_state_t;

   // Contact sense inputs from the relay being wetted.
   typedef struct packed {
      logic [CONTACTS-1:0] no_closed;
      logic [CONTACTS-1:0] nc_closed;
   } contact_sense_t;

   // Power and coil drives toward the relay being wetted.
   typedef struct packed {
      logic load_en;
      logic coil_pwr_en;
      logic set_coil;
      logic reset_coil;
   } relay_drive_t;
endpackage

/* core/relay_wetting_sequencer.sv */
// Sequencer that runs one contact wetting burst per start press.
`timescale 1ns/100ps
// Notes on behaviour
// - A press of start, fixture test or fixture retest begins a run.
// - Start presses during a run are ignored until it has completed.
// - A run issues 20 coil pulses, alternating between set and reset coils when bistable; monostable pulses only the set coil.
// - Pulses repeat at 1 Hz, 50/50 duty bistable, 45/55 monostable.
// - The wetting load is enabled while a run is active.
// - One LED per NO and NC contact shows load current during a run.
// - All contact LEDs go dark when the run ends.
// - After 20 cycles coil power and load power are removed.
// - The fan output stays on whenever the unit is out of reset; reset holds it off.
// - With a fixture attached, its test and retest lamps are lit.
module relay_wetting_sequencer
   import wetting_pkg::*;
#(
   parameter int unsigned PERIOD = PERIOD_CYCLES,
   parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES,
   parameter int unsigned PULSES = BURST_PULSES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic start_sw,
   input wire logic fixture_test_sw,
   input wire logic fixture_retest_sw,
   input wire logic fixture_present,
   input wire logic monostable_sel,
   input wire contact_sense_t relay_being_wetted_sense,
   output relay_drive_t relay_being_wetted_drive,
   output logic [CONTACTS-1:0] led_no,
   output logic [CONTACTS-1:0] led_nc,
   output logic fixture_lamps,
   output logic fan_en,
   output logic run_active
);
   localparam int unsigned CW = $clog2(PERIOD + 1);
   localparam int unsigned DW = $clog2(DEBOUNCE + 1);
   localparam int unsigned PW = $clog2(PULSES + 1);
   localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD - 1);
   // Products are formed at 64 bits, as a full-rate period times a percentage overflows 32 bits.
   localparam logic [CW-1:0] ON_BI = CW'((64'(PERIOD) * DUTY_BISTABLE_PCT) / PCT_FULL);
   localparam logic [CW-1:0] ON_MONO = CW'((64'(PERIOD) * DUTY_MONOSTABLE_PCT) / PCT_FULL);
   localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE - 1);
   localparam logic [PW-1:0] PULSE_LAST = PW'(PULSES - 1);

   // Refuse counts too small for a pulse of at least one cycle in each phase.
   if (PERIOD < 4 || DEBOUNCE < 1 || PULSES < 1) begin : g_param_check
      $error("relay_wetting_sequencer: period, debounce or pulse count too small");
   end

   // Two-stage synchronisers for the pins; only stage two is read onward.
   logic [NUM_SWITCHES-1:0] sw_meta_r, sw_sync_r;
   logic [2*CONTACTS-1:0] sense_meta_r, sense_sync_r;
   logic [1:0] cfg_meta_r, cfg_sync_r;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sw_meta_r <= '0;
         sw_sync_r <= '0;
         sense_meta_r <= '0;
         sense_sync_r <= '0;
         cfg_meta_r <= '0;
         cfg_sync_r <= '0;
      end else begin
         sw_meta_r <= {fixture_retest_sw, fixture_test_sw, start_sw};
         sw_sync_r <= sw_meta_r;
         sense_meta_r <= {relay_being_wetted_sense.no_closed, relay_being_wetted_sense.nc_closed};
         sense_sync_r <= sense_meta_r;
         cfg_meta_r <= {fixture_present, monostable_sel};
         cfg_sync_r <= cfg_meta_r;
      end
   end

   // Per-switch debounce: a level is accepted only after it holds steady.
   logic [NUM_SWITCHES-1:0] sw_clean_r, sw_clean_nxt;
   logic [DW-1:0] deb_cnt_r [NUM_SWITCHES];
   logic [DW-1:0] deb_cnt_nxt [NUM_SWITCHES];

   genvar g;
   generate
      for (g = 0; g < NUM_SWITCHES; g++) begin : g_deb
         always_comb begin
            sw_clean_nxt[g] = sw_clean_r[g];
            deb_cnt_nxt[g] = '0;
            if (sw_sync_r[g] != sw_clean_r[g]) begin
               if (deb_cnt_r[g] == DEB_LAST) begin
                  sw_clean_nxt[g] = sw_sync_r[g];
               end else begin
                  deb_cnt_nxt[g] = deb_cnt_r[g] + DW'(1);
               end
            end
         end

         // Hold the accepted level and the settle count of this switch.
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               sw_clean_r[g] <= 1'b0;
               deb_cnt_r[g] <= '0;
            end else begin
               sw_clean_r[g] <= sw_clean_nxt[g];
               deb_cnt_r[g] <= deb_cnt_nxt[g];
            end
         end
      end
   endgenerate

   // A switch held through the end of a run shows no fresh edge, so it cannot restart one.
   // one rising press edge
   logic press_any;
   logic [NUM_SWITCHES-1:0] sw_prev_r;
   assign press_any = |(sw_clean_r & ~sw_prev_r);

   // Sequencer state: phase counter, pulse count and which coil is next.
   seq_state_t state_r, state_nxt;
   logic [CW-1:0] phase_r, phase_nxt;
   logic [PW-1:0] pulse_r, pulse_nxt;
   logic coil_sel_r, coil_sel_nxt;
   logic mono_r, mono_nxt;
   logic [CW-1:0] on_len;

   assign on_len = mono_r ? ON_MONO : ON_BI;

   // Next-state logic of the run: idle, coil pulse on, coil pulse off.
   always_comb begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      pulse_nxt = pulse_r;
      coil_sel_nxt = coil_sel_r;
      mono_nxt = mono_r;
      unique case (state_r)
         ST_IDLE: begin
            if (press_any) begin
               state_nxt = ST_ON;
               phase_nxt = '0;
               pulse_nxt = '0;
               coil_sel_nxt = 1'b0;
               mono_nxt = cfg_sync_r[0];
            end
         end
         // presses are not looked at here
         ST_ON: begin
            phase_nxt = phase_r + CW'(1);
            if (phase_r == on_len - CW'(1)) begin
               state_nxt = ST_OFF;
            end
         end
         ST_OFF: begin
            phase_nxt = phase_r + CW'(1);
            if (phase_r == PERIOD_LAST) begin
               phase_nxt = '0;
               if (pulse_r == PULSE_LAST) begin
                  state_nxt = ST_IDLE;
               end else begin
                  state_nxt = ST_ON;
                  pulse_nxt = pulse_r + PW'(1);
                  coil_sel_nxt = ~coil_sel_r;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Output values computed from the next state so outputs are registered.
   relay_drive_t drive_nxt;
   logic [CONTACTS-1:0] led_no_nxt, led_nc_nxt;
   logic active_nxt;

   always_comb begin
      active_nxt = (state_nxt != ST_IDLE);
      // load and coil supply on during run
      drive_nxt.load_en = active_nxt;
      drive_nxt.coil_pwr_en = active_nxt;
      // Monostable relays have one coil, so only the set drive pulses.
      drive_nxt.set_coil = (state_nxt == ST_ON) && (!coil_sel_nxt || mono_nxt);
      drive_nxt.reset_coil = (state_nxt == ST_ON) && coil_sel_nxt && !mono_nxt;
      led_no_nxt = active_nxt ? sense_sync_r[2*CONTACTS-1:CONTACTS] : '0;
      led_nc_nxt = active_nxt ? sense_sync_r[CONTACTS-1:0] : '0;
   end

   // Register the sequencer state and every output of the block.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         phase_r <= '0;
         pulse_r <= '0;
         coil_sel_r <= 1'b0;
         mono_r <= 1'b0;
         sw_prev_r <= '0;
         relay_being_wetted_drive <= '0;
         led_no <= '0;
         led_nc <= '0;
         run_active <= 1'b0;
         fixture_lamps <= 1'b0;
         fan_en <= 1'b0;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         pulse_r <= pulse_nxt;
         coil_sel_r <= coil_sel_nxt;
         mono_r <= mono_nxt;
         sw_prev_r <= sw_clean_r;
         relay_being_wetted_drive <= drive_nxt;
         led_no <= led_no_nxt;
         led_nc <= led_nc_nxt;
         run_active <= active_nxt;
         fixture_lamps <= cfg_sync_r[1];
         fan_en <= 1'b1;
      end
   end
endmodule

/* sim/relay_model.sv */
// Behavioural model of the relay being wetted and its load current sense.
`timescale 1ns/100ps
module relay_model
   import wetting_pkg::*;
(
   input wire logic ref_clk,
   input wire logic mono,
   input wire relay_drive_t drv,
   output contact_sense_t sense
);
   logic latch_r = 1'b0;
   // A latching relay holds its armature between pulses; a monostable one follows its coil.
   always @(posedge ref_clk) begin
      if (drv.set_coil) latch_r <= 1'b1;
      else if (drv.reset_coil) latch_r <= 1'b0;
   end
   wire logic closed = mono ? drv.set_coil : latch_r;
   // Current only flows while the load is switched on.
   assign sense.no_closed = (drv.load_en && closed) ? 4'h5 : 4'h0;
   assign sense.nc_closed = (drv.load_en && !closed) ? 4'ha : 4'h0;
endmodule

/* sim/wetting_props.sv */
// Checker watching the sequencer's ports.
`timescale 1ns/100ps
module wetting_props
   import wetting_pkg::*;
#(
   parameter int unsigned PERIOD = 20,
   parameter int unsigned PULSES = 20
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic fixture_present,
   input wire relay_drive_t relay_being_wetted_drive,
   input wire logic [CONTACTS-1:0] led_no,
   input wire logic [CONTACTS-1:0] led_nc,
   input wire logic fixture_lamps,
   input wire logic fan_en,
   input wire logic run_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   relay_drive_t d;
   logic [15:0] run_cnt_r, run_cnt_nxt;
   assign d = relay_being_wetted_drive;
   // Counts active cycles so the burst length can be checked exactly.
   always_comb run_cnt_nxt = run_active ? run_cnt_r + 16'h1 : 16'h0;
   always_ff @(posedge ref_clk) run_cnt_r <= rstn ? run_cnt_nxt : 16'h0;
   fan_on_a: assert property (rstn && $past(rstn) |-> fan_en) else $error("fan off");
   lamps_a: assert property ($past(rstn,4) |-> fixture_lamps == $past(fixture_present,3)) else $error("lamps");
   leds_idle_a: assert property (!run_active |-> led_no == 4'h0 && led_nc == 4'h0) else $error("led idle");
   load_run_a: assert property (d.load_en == run_active) else $error("load");
   pwr_run_a: assert property (d.coil_pwr_en == run_active) else $error("coil power");
   coil_excl_a: assert property (!(d.set_coil && d.reset_coil)) else $error("both coils");
   coil_idle_a: assert property (!run_active |-> !d.set_coil && !d.reset_coil) else $error("coil idle");
   first_set_a: assert property ($rose(run_active) |-> d.set_coil && d.load_en) else $error("first pulse");
   burst_len_a: assert property ($fell(run_active) |-> run_cnt_r == PERIOD * PULSES) else $error("length");
   cover property ($rose(run_active));
   cover property ($rose(d.reset_coil));
   cover property ($fell(run_active));
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the relay wetting sequencer.
`timescale 1ns/100ps
module tb_top;
   import wetting_pkg::*;
   localparam int unsigned P = 20;
   localparam int unsigned N = 20;
   logic ref_clk = 1'b0, rstn = 1'b0, start_sw = 1'b0, test_sw = 1'b0, retest_sw = 1'b0;
   logic present = 1'b0, mono = 1'b0, lamps, fan_en, run_active;
   logic [CONTACTS-1:0] led_no, led_nc;
   contact_sense_t sense;
   relay_drive_t drv;
   int mismatches = 0, n_compared = 0;
   relay_wetting_sequencer #(.PERIOD(P), .DEBOUNCE(2), .PULSES(N)) i_relay_wetting_sequencer (.ref_clk(ref_clk),
      .rstn(rstn), .start_sw(start_sw), .fixture_test_sw(test_sw), .fixture_retest_sw(retest_sw),
      .fixture_present(present), .monostable_sel(mono), .relay_being_wetted_sense(sense),
      .relay_being_wetted_drive(drv), .led_no(led_no), .led_nc(led_nc), .fixture_lamps(lamps),
      .fan_en(fan_en), .run_active(run_active));
   relay_model i_relay_model (.ref_clk(ref_clk), .mono(mono), .drv(drv), .sense(sense));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic cmp(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Times one burst and sums coil on time; a press mid-run must not stretch it.
   task automatic measure(input int eset, input int erst);
      int n, ns, nr, nl, nn;
      n = 0;
      ns = 0;
      nr = 0;
      nl = 0;
      nn = 0;
      // Look one step after each edge so the first cycle of the run is counted too.
      #1;
      for (int i = 0; i < 50 && run_active !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      while (run_active === 1'b1 && n < 1000) begin
         n++;
         ns += drv.set_coil;
         nr += drv.reset_coil;
         nl += |led_no;
         nn += |led_nc;
         @(posedge ref_clk);
         if (n == 100) start_sw <= 1'b1;
         if (n == 106) start_sw <= 1'b0;
         #1;
      end
      cmp(n, P * N);
      cmp(ns, eset);
      cmp(nr, erst);
      cmp(nl != 0, 1'b1);
      cmp(nn != 0, 1'b1);
      cmp({drv, led_no, led_nc}, 16'h0);
      cmp(fan_en, 1'b1);
   endtask
   task automatic t_start_bistable();
      @(posedge ref_clk) start_sw <= 1'b1;
      repeat (3) @(posedge ref_clk);
      start_sw <= 1'b0;
      #1 cmp(lamps, 1'b0);
      measure(N / 2 * (P * DUTY_BISTABLE_PCT / PCT_FULL), N / 2 * (P * DUTY_BISTABLE_PCT / PCT_FULL));
   endtask
   task automatic t_test_mono();
      @(posedge ref_clk) begin
         mono <= 1'b1;
         present <= 1'b1;
         test_sw <= 1'b1;
      end
      repeat (3) @(posedge ref_clk);
      test_sw <= 1'b0;
      #1 cmp(lamps, 1'b1);
      measure(N * (P * DUTY_MONOSTABLE_PCT / PCT_FULL), 0);
      @(posedge ref_clk) mono <= 1'b0;
   endtask
   // Holding the switch through the end of a run must not start another.
   task automatic t_retest_held();
      @(posedge ref_clk) retest_sw <= 1'b1;
      measure(N / 2 * (P / 2), N / 2 * (P / 2));
      repeat (30) @(posedge ref_clk);
      #1 cmp(run_active, 1'b0);
      @(posedge ref_clk) retest_sw <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask
   task automatic close_out();
      if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_start_bistable();
      t_test_mono();
      t_retest_held();
      close_out();
   end
   // A hang is cut short well after the three bursts should have ended.
   initial begin
      #100us;
      mismatches++;
      close_out();
   end
endmodule
bind relay_wetting_sequencer wetting_props #(.PERIOD(PERIOD), .PULSES(PULSES)) i_wetting_props (.ref_clk(ref_clk),
   .rstn(rstn), .fixture_present(fixture_present), .relay_being_wetted_drive(relay_being_wetted_drive),
   .led_no(led_no), .led_nc(led_nc), .fixture_lamps(fixture_lamps), .fan_en(fan_en), .run_active(run_active));
